//--- hdl/phybc_params.svh
// Offsets, field positions, reset values and timing counts of the block.
`ifndef PHYBC_PARAMS_SVH
`define PHYBC_PARAMS_SVH

// Number of independent ports and bus address width.
`define PHYBC_PORTS        2
`define PHYBC_ADDR_W       4
`define PHYBC_DATA_W       32

// Byte offsets; address bit PHYBC_PORT_BIT selects the port.
`define PHYBC_OFS_CTRL     4'h0
`define PHYBC_OFS_STAT     4'h8
`define PHYBC_PORT_BIT     2

// Control word field positions.
`define PHYBC_B_SOFT_RST   15
`define PHYBC_B_LOOPBACK   14
`define PHYBC_B_SPEED      13
`define PHYBC_B_AN_EN      12
`define PHYBC_B_PWR_DOWN   11
`define PHYBC_B_ISOLATE    10
`define PHYBC_B_RESTART    9
`define PHYBC_B_DUPLEX     8
`define PHYBC_B_COL_TEST   7
`define PHYBC_RSVD_W       7
`define PHYBC_LANE_W       8

// Status word field positions.
`define PHYBC_S_PD         0
`define PHYBC_S_AN_PEND    1
`define PHYBC_S_SPEED      2
`define PHYBC_S_DUPLEX     3
`define PHYBC_S_ISOLATE    4
`define PHYBC_S_COL        5

// Reset values of the non-strapped control fields.
`define PHYBC_RST_ZERO     1'b0

// Timing: clock rate, bit time at the fastest rate, collision bounds.
`define PHYBC_CLK_MHZ      100
`define PHYBC_BIT_NS       10
`define PHYBC_COL_ON_BITS  512
`define PHYBC_COL_OFF_BITS 4
`define PHYBC_COL_ON_CYC  ((`PHYBC_COL_ON_BITS*`PHYBC_BIT_NS*`PHYBC_CLK_MHZ)/1000)
`define PHYBC_COL_OFF_CYC ((`PHYBC_COL_OFF_BITS*`PHYBC_BIT_NS*`PHYBC_CLK_MHZ)/1000)

`endif

//--- hdl/phybc_pkg.sv
// Types shared by the basic mode control block.
package phybc_pkg;

    // Control word, laid out exactly as software sees it.
    typedef struct packed {
        logic       soft_reset;
        logic       loopback;
        logic       speed_100;
        logic       an_enable;
        logic       power_down;
        logic       isolate;
        logic       restart;
        logic       full_duplex;
        logic       col_test;
        logic [6:0] rsvd;
    } phybc_ctrl_t;

    // Avalon-MM request bundle from the master.
    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } phybc_avs_req_t;

    // Strap pins of one port.
    typedef struct packed {
        logic an_enable;
        logic speed_100;
        logic full_duplex;
        logic fiber_mode_select;
    } phybc_strap_t;

    // Bus answer sequencer.
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DONE = 2'b10
    } phybc_bus_st_t;

endpackage : phybc_pkg

//--- hdl/phybc_pinsync.sv
// Three-stage pin synchroniser with agreement filter and gated output.
`timescale 1ns/1ns

module phybc_pinsync #(
    parameter int               WIDTH    = 1,
    parameter logic [WIDTH-1:0] IDLE_VAL = '0
) (
    // Clock and reset.
    input  logic             i_mclk,
    input  logic             i_rst,
    // Pin side.
    input  logic [WIDTH-1:0] i_pin,
    // Gate and results.
    input  logic [WIDTH-1:0] i_en,
    output logic [WIDTH-1:0] o_level,
    output logic [WIDTH-1:0] o_gated
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] level_q;
    logic [WIDTH-1:0] level_d;
    logic [WIDTH-1:0] gated_q;

    // A bit moves only once the second and third stages agree.
    assign level_d = (s2_q & s3_q) | (level_q & (s2_q ^ s3_q));

    // Synchroniser chain; the first stage feeds only the second.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            s1_q <= IDLE_VAL;
            s2_q <= IDLE_VAL;
            s3_q <= IDLE_VAL;
        end else begin
            s1_q <= i_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Filtered level and gated copy update on the same edge, which saves
    // a cycle of latency on the gated path.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            level_q <= IDLE_VAL;
            gated_q <= '0;
        end else begin
            level_q <= level_d;
            gated_q <= level_d & i_en;
        end
    end

    assign o_level = level_q;
    assign o_gated = gated_q;

endmodule : phybc_pinsync

//--- hdl/phybc_ctrl.sv
// Two-port basic mode control register bank behind an Avalon-MM slave.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ns
`include "phybc_params.svh"

////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Power-down stops port, registers stay reachable.
// - Power-down bit ORed with low-active pin.
// - Isolate cuts MII, management still works.
// - Writing restart one restarts auto-negotiation.
// - Restart write ignored while auto-negotiation off.
// - Restart reads one until initiated, then clears.
// - Writing restart zero leaves negotiation running.
// - Duplex bit picks full or half duplex.
// - Collision test raises COL after TX_EN rises.
// - Collision test drops COL after TX_EN falls.
// - Low seven control bits reserved, read zero.
// - Auto-negotiation on overrides speed and duplex.
// - Speed bit picks 100 or 10 Mb/s.
// - Fiber mode forces auto-negotiation off at reset.
module phybc_ctrl #(
    parameter int PORTS = `PHYBC_PORTS
) (
    // Clock and reset.
    input  logic                             i_mclk,
    input  logic                             i_rst,
    // Avalon-MM slave.
    input  phybc_pkg::phybc_avs_req_t        i_avs,
    output logic [`PHYBC_DATA_W-1:0]         o_avs_readdata,
    output logic                             o_avs_waitrequest,
    // Pins: power-down request and straps.
    input  logic                             i_low_power_request_pin_n,
    input  phybc_pkg::phybc_strap_t [PORTS-1:0] i_strap,
    // MII side, one bit per port.
    input  logic [PORTS-1:0]                 i_mii_tx_en,
    output logic [PORTS-1:0]                 o_mii_col,
    output logic [PORTS-1:0]                 o_mii_oe_n,
    // Auto-negotiation engine handshake and results.
    output logic [PORTS-1:0]                 o_an_restart,
    input  logic [PORTS-1:0]                 i_an_ack,
    input  logic [PORTS-1:0]                 i_an_speed_100,
    input  logic [PORTS-1:0]                 i_an_full_duplex,
    // Effective port mode.
    output logic [PORTS-1:0]                 o_power_down,
    output logic [PORTS-1:0]                 o_speed_100,
    output logic [PORTS-1:0]                 o_full_duplex,
    output logic [PORTS-1:0]                 o_an_enable,
    output logic [PORTS-1:0]                 o_loopback
);

    import phybc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Address decode helpers; is_ctrl and port_of serve the read and the write path, is_stat the read path only.
    function automatic logic is_ctrl(input logic [`PHYBC_ADDR_W-1:0] a);
        logic [`PHYBC_ADDR_W-1:0] b;
        b = a;
        b[`PHYBC_PORT_BIT] = 1'b0;
        return b == `PHYBC_OFS_CTRL;
    endfunction : is_ctrl

    function automatic logic is_stat(input logic [`PHYBC_ADDR_W-1:0] a);
        logic [`PHYBC_ADDR_W-1:0] b;
        b = a;
        b[`PHYBC_PORT_BIT] = 1'b0;
        return b == `PHYBC_OFS_STAT;
    endfunction : is_stat

    function automatic logic port_of(input logic [`PHYBC_ADDR_W-1:0] a);
        return a[`PHYBC_PORT_BIT];
    endfunction : port_of

    // Strapped control value, used at reset and at a soft reset.
    function automatic phybc_ctrl_t strap_value(input phybc_strap_t s);
        phybc_ctrl_t c;
        c             = '0;
        c.speed_100   = s.speed_100;
        c.full_duplex = s.full_duplex;
        c.an_enable   = s.an_enable & ~s.fiber_mode_select;
        return c;
    endfunction : strap_value

    ////////////////////////////////////////////////////////////////////////
    phybc_bus_st_t             st_q;
    phybc_bus_st_t             st_d;
    logic                      req;
    logic                      wr_acc;
    logic [`PHYBC_DATA_W-1:0]  rdata_q;
    logic [`PHYBC_DATA_W-1:0]  rdata_d;
    logic                      pin_level;
    logic                      pin_pd;
    phybc_ctrl_t               ctrl_q [PORTS];
    phybc_ctrl_t               wval;
    logic [15:0]               wbits;
    logic [15:0]               ctrl_rd [PORTS];
    logic [15:0]               stat_rd [PORTS];
    logic [PORTS-1:0]          wsel;
    logic [PORTS-1:0]          set_rst;
    logic [PORTS-1:0]          restart_q;
    logic [PORTS-1:0]          pd_eff;
    logic [PORTS-1:0]          col_en;
    logic [PORTS-1:0]          pd_q;
    logic [PORTS-1:0]          speed_q;
    logic [PORTS-1:0]          duplex_q;

    ////////////////////////////////////////////////////////////////////////
    // Bus sequencer: every access waits exactly one cycle, then completes.
    assign req = i_avs.read | i_avs.write;
    assign o_avs_waitrequest = req & (st_q == BUS_IDLE);
    assign wr_acc = i_avs.write & (st_q == BUS_DONE);

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            BUS_IDLE: begin
                if (req) begin
                    st_d = BUS_DONE;
                end
            end
            BUS_DONE: begin
                st_d = BUS_IDLE;
            end
            default: begin
                st_d = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st_q <= BUS_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // Read mux; unmapped offsets read as zero and writes to them vanish.
    always_comb begin
        rdata_d = '0;
        if (is_ctrl(i_avs.address)) begin
            rdata_d[15:0] = ctrl_rd[port_of(i_avs.address)];
        end else if (is_stat(i_avs.address)) begin
            rdata_d[15:0] = stat_rd[port_of(i_avs.address)];
        end
    end

    // Read data is captured in the wait cycle so it stands at completion.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rdata_q <= '0;
        end else if (i_avs.read && st_q == BUS_IDLE) begin
            rdata_q <= rdata_d;
        end
    end

    assign o_avs_readdata = rdata_q;

    // Byte-lane merge over the addressed port's current control word.
    always_comb begin
        wbits = ctrl_q[port_of(i_avs.address)];
        if (i_avs.byteenable[0]) begin
            wbits[`PHYBC_LANE_W-1:0] = i_avs.writedata[`PHYBC_LANE_W-1:0];
        end
        if (i_avs.byteenable[1]) begin
            wbits[15:`PHYBC_LANE_W] = i_avs.writedata[15:`PHYBC_LANE_W];
        end
        wval = phybc_ctrl_t'(wbits);
    end

    ////////////////////////////////////////////////////////////////////////
    // The power-down pin is shared by both ports and idles high.
    phybc_pinsync #(
        .WIDTH    (1),
        .IDLE_VAL (1'b1)
    ) u_pd_sync (
        .i_mclk   (i_mclk),
        .i_rst    (i_rst),
        .i_pin    (i_low_power_request_pin_n),
        .i_en     (1'b1),
        .o_level  (pin_level),
        .o_gated  ()
    );

    assign pin_pd = ~pin_level;

    // TX_EN arrives on the MAC's transmit clock; COL comes straight out of
    // the filter stage so the drop stays inside four bit times at 100 Mb/s.
    phybc_pinsync #(
        .WIDTH    (PORTS),
        .IDLE_VAL ('0)
    ) u_txen_sync (
        .i_mclk   (i_mclk),
        .i_rst    (i_rst),
        .i_pin    (i_mii_tx_en),
        .i_en     (col_en),
        .o_level  (),
        .o_gated  (o_mii_col)
    );

    ////////////////////////////////////////////////////////////////////////
    for (genvar p = 0; p < PORTS; p++) begin : g_port
        localparam int OTHER = PORTS - 1 - p;

        assign wsel[p] = wr_acc && is_ctrl(i_avs.address)
                         && (port_of(i_avs.address) == 1'(p));
        assign set_rst[p] = wsel[p] & wval.soft_reset;

        // Stored control fields; straps load at reset and soft reset.
        always_ff @(posedge i_mclk) begin
            if (i_rst || set_rst[p]) begin
                ctrl_q[p] <= strap_value(i_strap[p]);
            end else if (wsel[p]) begin
                ctrl_q[p]             <= wval;
                ctrl_q[p].soft_reset  <= `PHYBC_RST_ZERO;
                ctrl_q[p].restart     <= `PHYBC_RST_ZERO;
                ctrl_q[p].rsvd        <= '0;
            end
        end

        // Restart pending: a new request beats a same-cycle acknowledge.
        always_ff @(posedge i_mclk) begin
            if (i_rst || set_rst[p]) begin
                restart_q[p] <= 1'b0;
            end else if (wsel[p] && wval.restart && wval.an_enable) begin
                restart_q[p] <= 1'b1;
            end else if (i_an_ack[p] || !ctrl_q[p].an_enable) begin
                restart_q[p] <= 1'b0;
            end
        end

        // Pin request ORs into the stored bit.
        assign pd_eff[p] = ctrl_q[p].power_down | pin_pd;

        // Shut the MII while down or isolated, and negotiation only while down.
        assign o_an_restart[p] = restart_q[p] & ~pd_eff[p];
        assign o_mii_oe_n[p]   = pd_eff[p] | ctrl_q[p].isolate;
        assign col_en[p] = ctrl_q[p].col_test & ~pd_eff[p]
                           & ~ctrl_q[p].isolate;

        // Effective mode follows the engine only when negotiating.
        always_ff @(posedge i_mclk) begin
            if (i_rst) begin
                pd_q[p]     <= 1'b0;
                speed_q[p]  <= 1'b0;
                duplex_q[p] <= 1'b0;
            end else begin
                pd_q[p] <= pd_eff[p];
                speed_q[p] <= ctrl_q[p].an_enable ? i_an_speed_100[p]
                                                  : ctrl_q[p].speed_100;
                duplex_q[p] <= ctrl_q[p].an_enable ? i_an_full_duplex[p]
                                                   : ctrl_q[p].full_duplex;
            end
        end

        assign o_power_down[p]  = pd_q[p];
        assign o_speed_100[p]   = speed_q[p];
        assign o_full_duplex[p] = duplex_q[p];
        assign o_an_enable[p]   = ctrl_q[p].an_enable;
        assign o_loopback[p]    = ctrl_q[p].loopback;

        // Readback shows pending restart and the ORed power-down.
        assign ctrl_rd[p] = {1'b0, ctrl_q[p].loopback, ctrl_q[p].speed_100,
                             ctrl_q[p].an_enable, pd_eff[p],
                             ctrl_q[p].isolate, restart_q[p],
                             ctrl_q[p].full_duplex, ctrl_q[p].col_test,
                             `PHYBC_RSVD_W'h00};

        always_comb begin
            stat_rd[p] = '0;
            stat_rd[p][`PHYBC_S_PD]      = pd_eff[p];
            stat_rd[p][`PHYBC_S_AN_PEND] = restart_q[p];
            stat_rd[p][`PHYBC_S_SPEED]   = speed_q[p];
            stat_rd[p][`PHYBC_S_DUPLEX]  = duplex_q[p];
            stat_rd[p][`PHYBC_S_ISOLATE] = ctrl_q[p].isolate;
            stat_rd[p][`PHYBC_S_COL]     = o_mii_col[p];
        end

        // Checks on the port's behaviour.
        property p_pd_gate;
            @(posedge i_mclk) disable iff (i_rst)
            pd_eff[p] |-> (o_mii_oe_n[p] && !o_an_restart[p])
                          ##1 !o_mii_col[p];
        endproperty
        a_pd_gate: assert property (p_pd_gate)
            else $error("port active while powered down");

        property p_pd_pin;
            @(posedge i_mclk) disable iff (i_rst)
            (!i_low_power_request_pin_n)[*5] |=> o_power_down[p];
        endproperty
        a_pd_pin: assert property (p_pd_pin)
            else $error("power-down pin not honoured");

        property p_iso;
            @(posedge i_mclk) disable iff (i_rst)
            ctrl_q[p].isolate |-> o_mii_oe_n[p] ##1 !o_mii_col[p];
        endproperty
        a_iso: assert property (p_iso)
            else $error("isolated port drives MII");

        property p_restart_set;
            @(posedge i_mclk) disable iff (i_rst)
            (wsel[p] && wval.restart && wval.an_enable && !wval.soft_reset)
            |=> restart_q[p] && ctrl_rd[p][`PHYBC_B_RESTART];
        endproperty
        a_restart_set: assert property (p_restart_set)
            else $error("restart write not taken");

        property p_restart_ign;
            @(posedge i_mclk) disable iff (i_rst)
            (wsel[p] && wval.restart && !wval.an_enable && !restart_q[p])
            |=> !restart_q[p] && !o_an_restart[p];
        endproperty
        a_restart_ign: assert property (p_restart_ign)
            else $error("restart taken with negotiation off");

        property p_restart_hold;
            @(posedge i_mclk) disable iff (i_rst)
            (restart_q[p] && !i_an_ack[p] && !wsel[p]
             && ctrl_q[p].an_enable) |=> restart_q[p];
        endproperty
        a_restart_hold: assert property (p_restart_hold)
            else $error("restart cleared before initiation");

        property p_restart_clr;
            @(posedge i_mclk) disable iff (i_rst)
            (restart_q[p] && i_an_ack[p] && !wsel[p])
            |=> !ctrl_rd[p][`PHYBC_B_RESTART];
        endproperty
        a_restart_clr: assert property (p_restart_clr)
            else $error("restart did not self-clear");

        property p_restart_wr0;
            @(posedge i_mclk) disable iff (i_rst)
            (wsel[p] && !wval.restart && wval.an_enable && !wval.soft_reset
             && restart_q[p] && !i_an_ack[p]) |=> restart_q[p];
        endproperty
        a_restart_wr0: assert property (p_restart_wr0)
            else $error("zero write disturbed negotiation");

        property p_duplex;
            @(posedge i_mclk) disable iff (i_rst)
            !ctrl_q[p].an_enable
            |=> o_full_duplex[p] == $past(ctrl_q[p].full_duplex);
        endproperty
        a_duplex: assert property (p_duplex)
            else $error("forced duplex not applied");

        property p_speed;
            @(posedge i_mclk) disable iff (i_rst)
            !ctrl_q[p].an_enable
            |=> o_speed_100[p] == $past(ctrl_q[p].speed_100);
        endproperty
        a_speed: assert property (p_speed)
            else $error("forced speed not applied");

        property p_an_mode;
            @(posedge i_mclk) disable iff (i_rst)
            ctrl_q[p].an_enable
            |=> (o_speed_100[p] == $past(i_an_speed_100[p]))
                && (o_full_duplex[p] == $past(i_an_full_duplex[p]));
        endproperty
        a_an_mode: assert property (p_an_mode)
            else $error("negotiated mode not used");

        property p_fiber;
            @(posedge i_mclk)
            ($past(i_rst) && !i_rst && $past(i_strap[p].fiber_mode_select))
            |-> !ctrl_q[p].an_enable;
        endproperty
        a_fiber: assert property (p_fiber)
            else $error("fiber reset left negotiation on");

        property p_col_on;
            @(posedge i_mclk) disable iff (i_rst)
            (i_mii_tx_en[p] && col_en[p])[*4] |=> o_mii_col[p];
        endproperty
        a_col_on: assert property (p_col_on)
            else $error("collision test COL late");

        property p_col_off;
            @(posedge i_mclk) disable iff (i_rst)
            (!i_mii_tx_en[p])[*4] |=> !o_mii_col[p];
        endproperty
        a_col_off: assert property (p_col_off)
            else $error("collision test COL stuck");

        property p_indep;
            @(posedge i_mclk) disable iff (i_rst)
            wsel[p] |=> $stable(ctrl_q[OTHER])
                        && ($stable(restart_q[OTHER])
                            || $past(i_an_ack[OTHER]));
        endproperty
        a_indep: assert property (p_indep)
            else $error("write leaked to other port");
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus-level checks.
    property p_rsvd;
        @(posedge i_mclk) disable iff (i_rst)
        (st_q == BUS_DONE && i_avs.read && is_ctrl(i_avs.address))
        |-> o_avs_readdata[`PHYBC_RSVD_W-1:0] == '0;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bits read nonzero");

    property p_iso_bus;
        @(posedge i_mclk) disable iff (i_rst)
        (req && st_q == BUS_IDLE) |=> !o_avs_waitrequest;
    endproperty
    a_iso_bus: assert property (p_iso_bus)
        else $error("management access stalled");

endmodule : phybc_ctrl

//--- tb/phybc_an_model.sv
// Behavioural auto-negotiation engine that acknowledges restart requests.
`timescale 1ns/1ns

module phybc_an_model #(
    parameter int DELAY = 30
) (
    // Clock and reset.
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    // Restart request in, initiated pulse out.
    input  wire logic [1:0] i_restart,
    output logic      [1:0] o_ack
);
    int cnt [2];

    // A slow answer keeps the request pending long enough to be read back.
    always_ff @(posedge i_mclk) begin
        for (int p = 0; p < 2; p++) begin
            if (i_rst || !i_restart[p]) begin
                cnt[p]   <= 0;
                o_ack[p] <= 1'b0;
            end else begin
                cnt[p]   <= (cnt[p] == DELAY) ? 0 : cnt[p] + 1;
                o_ack[p] <= (cnt[p] == DELAY);
            end
        end
    end
endmodule : phybc_an_model

//--- tb/phy_basic_control_lower_bits_tb.sv
// Self-checking bench for the two-port basic mode control bank.
`timescale 1ns/1ns
`include "phybc_params.svh"

module phy_basic_control_lower_bits_tb;
    import phybc_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst  = 1'b1;
    phybc_avs_req_t avs = '0;
    logic [31:0] rdata;
    logic wreq, pin_n = 1'b1;
    phybc_strap_t [1:0] strap = {4'b1011, 4'b1110};
    logic [1:0] tx_en = '0, col, oe_n, anr, ack, an_sp = '0, an_dp = '0;
    logic [1:0] pd, sp, dp, ane, lb;
    logic [15:0] q;
    logic [31:0] seed = 32'h0000000D;
    int miscompares = 0, checks_done = 0, n;

    always #5 i_mclk = ~i_mclk;

    phybc_ctrl u_phybc_ctrl (.i_mclk(i_mclk), .i_rst(i_rst), .i_avs(avs),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_low_power_request_pin_n(pin_n), .i_strap(strap),
        .i_mii_tx_en(tx_en), .o_mii_col(col), .o_mii_oe_n(oe_n),
        .o_an_restart(anr), .i_an_ack(ack), .i_an_speed_100(an_sp),
        .i_an_full_duplex(an_dp), .o_power_down(pd), .o_speed_100(sp),
        .o_full_duplex(dp), .o_an_enable(ane), .o_loopback(lb));
    phybc_an_model u_phybc_an_model (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_restart(anr), .o_ack(ack));

    ////////////////////////////////////////////////////////////////////////
    // Xorshift source, fixed start so every run repeats.
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // Expected readback of a write with negotiation off and no soft reset.
    function automatic logic [15:0] exp_ctrl(input logic [15:0] d);
        return d & 16'h7D80;
    endfunction : exp_ctrl

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk

    // One Avalon cycle; waitrequest and read data are taken at the rising
    // edge, before the design's own updates of that edge land.
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [15:0] d, output logic [15:0] r);
        @(posedge i_mclk);
        avs <= '{read: !wr, write: wr, address: a, byteenable: 4'h3,
                 writedata: {16'h0000, d}};
        do begin
            @(posedge i_mclk);
        end while (wreq !== 1'b0);
        r = rdata[15:0];
        avs <= '0;
    endtask : bus

    task automatic final_report;
        if (miscompares == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////
    // Watchdog sized well past the whole sequence.
    initial begin
        repeat (20000) @(posedge i_mclk);
        miscompares++;
        final_report();
    end

    // Main sequence.
    initial begin
        repeat (20) @(posedge i_mclk);
        i_rst <= 1'b0;
        bus(0, 4'h0, 0, q); chk("ctrl0 reset", 16'h3100, q);
        bus(0, 4'h4, 0, q); chk("ctrl1 reset", 16'h0100, q);
        for (int i = 0; i < 24; i++) begin
            seed = xs(seed);
            bus(1, 4'h0, seed[15:0] & 16'h6FFF, q);
            bus(0, 4'h0, 0, q);
            chk("ctrl0 rand", exp_ctrl(seed[15:0] & 16'h6FFF), q);
        end
        bus(0, 4'h4, 0, q); chk("ctrl1 kept", 16'h0100, q);
        bus(0, 4'h2, 0, q); chk("unmapped", 16'h0000, q);
        bus(1, 4'h0, 16'h1200, q);
        bus(0, 4'h0, 0, q); chk("restart pend", 16'h1200, q);
        chk("an restart", 16'h0001, {14'h0, anr});
        bus(1, 4'h0, 16'h1000, q);
        bus(0, 4'h0, 0, q); chk("restart kept", 16'h1200, q);
        n = 0;
        while (ack[0] !== 1'b1 && n < 200) begin
            @(negedge i_mclk);
            n++;
        end
        bus(0, 4'h0, 0, q); chk("restart done", 16'h1000, q);
        seed = xs(seed);
        an_sp <= seed[1:0];
        an_dp <= seed[3:2];
        repeat (4) @(posedge i_mclk);
        chk("an mode", {12'h0, 1'b1, seed[2], 1'b0, seed[0]},
            {12'h0, dp, sp});
        bus(1, 4'h0, 16'h0200, q);
        bus(0, 4'h0, 0, q); chk("restart off", 16'h0000, q);
        bus(1, 4'h0, 16'h6100, q);
        repeat (3) @(posedge i_mclk);
        chk("forced mode", 16'h0001, {15'h0, sp[0] & dp[0]});
        chk("mode pins", 16'h0001, {12'h0, ane, lb});
        bus(0, 4'h8, 0, q); chk("status0", 16'h000C, q);
        bus(1, 4'h0, 16'h1000, q);
        bus(1, 4'h4, 16'h0500, q);
        @(negedge i_mclk);
        chk("isolate oe", 16'h0002, {14'h0, oe_n});
        bus(0, 4'h4, 0, q); chk("isolate mgmt", 16'h0500, q);
        bus(1, 4'h4, 16'h0100, q);
        pin_n <= 1'b0;
        repeat (10) @(posedge i_mclk);
        bus(0, 4'h0, 0, q); chk("pin pd", 16'h1800, q);
        chk("pd out", 16'h0303, {6'h0, pd, 6'h0, oe_n});
        pin_n <= 1'b1;
        repeat (10) @(posedge i_mclk);
        chk("pd off", 16'h0000, {14'h0, pd});
        bus(1, 4'h0, 16'h0080, q);
        tx_en <= 2'b11;
        n = 0;
        do begin
            @(negedge i_mclk);
            n++;
        end while (col[0] !== 1'b1 && n < 600);
        chk("col on", 16'h0001, {15'h0, n <= `PHYBC_COL_ON_CYC});
        chk("col port1", 16'h0000, {15'h0, col[1]});
        @(posedge i_mclk);
        tx_en <= 2'b00;
        @(negedge i_mclk);
        n = 0;
        while (col[0] !== 1'b0 && n < 600) begin
            @(negedge i_mclk);
            n++;
        end
        chk("col off", 16'h0001, {15'h0, n <= `PHYBC_COL_OFF_CYC});
        final_report();
    end
endmodule : phy_basic_control_lower_bits_tb
